// [system_clock_power_mode_ctrl.sv]
// system clock source, divider and halt power mode controller
`timescale 1ns/1ns
`include "clk_mode_params.svh"
module system_clock_power_mode_ctrl #(
	parameter int SETTLE_CYC = `OSC_SETTLE_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire clk_mode_pkg::reg_req_t req,
	output logic [7:0] rdata,
	input wire logic halt_exec,
	input wire logic wdt_enable,
	input wire logic xtal_predivide,
	input wire logic xtal_postdivide,
	input wire logic fast_rc_clk_in,
	input wire logic crystal_clk_in,
	input wire logic slow_rc_clk_in,
	input wire logic port_wake_in,
	input wire logic timebase_wake_in,
	output logic sys_clk,
	output clk_mode_pkg::pwr_ctl_t pwr,
	output clk_mode_pkg::pwr_mode_t mode,
	output logic powerdown_flag_set,
	output logic watchdog_timeout_flag_clr,
	output logic watchdog_clear,
	output logic wake_restart,
	output logic regulator_lowpower_sel,
	output logic io_isolate
);
	import clk_mode_pkg::*;

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	logic [2:0] sysclk_div_sel_reg; // divide / sub select
	logic fast_src_sel_reg; // 0 fast rc, 1 crystal
	logic fast_osc_idle_en_reg; // fast osc runs in halt
	logic slow_osc_idle_en_reg; // slow osc runs in halt
	logic irc_osc_en_reg; // fast rc enable
	logic xtal_osc_en_reg; // crystal enable
	logic irc_stable_flag_reg; // fast rc stable
	logic xtal_stable_flag_reg; // crystal stable
	logic deep_power_down_reg; // halt goes deep
	logic io_iso_reg; // io isolation request
	logic lp_reg; // regulator low power select
	logic main_domain_por_flag_reg; // power on flag
	logic port_wake_flag_reg; // woke by port
	logic timebase_wake_flag_reg; // woke by timebase
	logic [15:0] irc_cnt_reg; // rc settle count
	logic [15:0] xtal_cnt_reg; // crystal settle count
	pwr_mode_t mode_reg; // present operating mode
	logic wake_reset; // deep sleep wake reset pulse
	logic soft_rst; // register reset
	logic wr_sel, wr_irc, wr_xtal, wr_pwr; // write decodes
	logic wake_by_port_reg; // deep sleep left through the port edge
	logic wake_by_tb_reg; // deep sleep left through the time base
	logic port_fall; // synced falling edge on the port wake pin

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] s_frc, s_xtl, s_slw, s_pw, s_tw; // two stage syncs
	logic frc_prev, xtl_prev, slw_prev, pw_prev; // edge history on second stage

	// capture asynchronous inputs through two flops
	always_ff @(posedge ref_clk) begin
		s_frc <= {s_frc[0], fast_rc_clk_in};
		s_xtl <= {s_xtl[0], crystal_clk_in};
		s_slw <= {s_slw[0], slow_rc_clk_in};
		s_pw <= {s_pw[0], port_wake_in};
		s_tw <= {s_tw[0], timebase_wake_in};
		frc_prev <= s_frc[1];
		xtl_prev <= s_xtl[1];
		slw_prev <= s_slw[1];
		pw_prev <= s_pw[1];
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	// a deep sleep wake reloads every register as a power-on would; the por flag
	// and isolation are kept and the wake flags record the source so software can tell why it restarted
	assign soft_rst = rst | wake_reset;
	// a falling port level ends deep sleep
	assign port_fall = pw_prev && !s_pw[1];
	assign wr_sel = req.wr && req.addr == `ADDR_SYSCLK_SEL;
	assign wr_irc = req.wr && req.addr == `ADDR_IRC_CTRL;
	assign wr_xtal = req.wr && req.addr == `ADDR_XTAL_CTRL;
	assign wr_pwr = req.wr && req.addr == `ADDR_PWR_CTRL;

	// clock select register
	always_ff @(posedge ref_clk) begin
		if (soft_rst) begin
			sysclk_div_sel_reg <= 3'(`RST_SYSCLK_SEL >> `BIT_DIV_LO);
			fast_src_sel_reg <= 1'b0;
			fast_osc_idle_en_reg <= 1'b0;
			slow_osc_idle_en_reg <= 1'b0;
		end else if (wr_sel) begin
			sysclk_div_sel_reg <= req.wdata[`BIT_DIV_HI:`BIT_DIV_LO];
			fast_src_sel_reg <= req.wdata[`BIT_FAST_SRC];
			fast_osc_idle_en_reg <= req.wdata[`BIT_FAST_IDLE];
			slow_osc_idle_en_reg <= req.wdata[`BIT_SLOW_IDLE];
		end
	end

	// oscillator enables, rc on and crystal off at power up
	always_ff @(posedge ref_clk) begin
		if (soft_rst) begin
			irc_osc_en_reg <= `RST_IRC_EN;
			xtal_osc_en_reg <= `RST_XTAL_EN;
		end else begin
			if (wr_irc)
				irc_osc_en_reg <= req.wdata[`BIT_OSC_EN];
			if (wr_xtal)
				xtal_osc_en_reg <= req.wdata[`BIT_OSC_EN];
		end
	end

	// stable flags: cleared on enable, set after settle edges counted
	always_ff @(posedge ref_clk) begin
		if (soft_rst || (wr_irc && req.wdata[`BIT_OSC_EN]) || !irc_osc_en_reg) begin
			irc_cnt_reg <= 16'h0000;
			irc_stable_flag_reg <= 1'b0;
		end else if (s_frc[1] && !frc_prev) begin
			if (irc_cnt_reg >= 16'(SETTLE_CYC))
				irc_stable_flag_reg <= 1'b1;
			else
				irc_cnt_reg <= irc_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (soft_rst || (wr_xtal && req.wdata[`BIT_OSC_EN]) || !xtal_osc_en_reg) begin
			xtal_cnt_reg <= 16'h0000;
			xtal_stable_flag_reg <= 1'b0;
		end else if (s_xtl[1] && !xtl_prev) begin
			if (xtal_cnt_reg >= 16'(SETTLE_CYC))
				xtal_stable_flag_reg <= 1'b1;
			else
				xtal_cnt_reg <= xtal_cnt_reg + 16'h0001;
		end
	end

	// power control register; wake flags set on wake, set beats clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			deep_power_down_reg <= 1'b0;
			io_iso_reg <= 1'b0;
			lp_reg <= 1'b0;
			main_domain_por_flag_reg <= 1'(`RST_PWR_CTRL >> `BIT_POR_FLAG);
			port_wake_flag_reg <= 1'b0;
			timebase_wake_flag_reg <= 1'b0;
		end else if (wake_reset) begin
			deep_power_down_reg <= 1'b0;
			io_iso_reg <= io_iso_reg; // isolation held until software releases
			lp_reg <= 1'b0;
			port_wake_flag_reg <= wake_by_port_reg;
			timebase_wake_flag_reg <= wake_by_tb_reg;
		end else if (wr_pwr) begin
			deep_power_down_reg <= req.wdata[`BIT_DEEP_PD];
			io_iso_reg <= req.wdata[`BIT_IO_ISO];
			lp_reg <= req.wdata[`BIT_REG_LP];
			main_domain_por_flag_reg <= req.wdata[`BIT_POR_FLAG];
			port_wake_flag_reg <= req.wdata[`BIT_PORT_WAKE];
			timebase_wake_flag_reg <= req.wdata[`BIT_TB_WAKE];
		end
	end

	// ----------------------------------------
	// read port, data one cycle after strobe
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst)
			rdata <= 8'h00;
		else if (req.rd) begin
			case (req.addr)
				`ADDR_SYSCLK_SEL: rdata <= {sysclk_div_sel_reg, 1'b0, fast_src_sel_reg, 1'b0,
					fast_osc_idle_en_reg, slow_osc_idle_en_reg};
				`ADDR_IRC_CTRL: rdata <= {6'h00, irc_stable_flag_reg, irc_osc_en_reg};
				`ADDR_XTAL_CTRL: rdata <= {6'h00, xtal_stable_flag_reg, xtal_osc_en_reg};
				`ADDR_PWR_CTRL: rdata <= {port_wake_flag_reg, 2'h0, timebase_wake_flag_reg,
					main_domain_por_flag_reg, lp_reg, io_iso_reg, deep_power_down_reg};
				default: rdata <= 8'h00;
			endcase
		end else
			rdata <= 8'h00;
	end

	// ----------------------------------------
	// halt mode sequencer
	// ----------------------------------------
	logic entry_pulse; // sleep or idle entry

	// pick the halt mode from the control bits, leave on wake
	always_ff @(posedge ref_clk) begin
		wake_reset <= 1'b0;
		entry_pulse <= 1'b0;
		if (rst)
			mode_reg <= m_run;
		else begin
			case (mode_reg)
				m_run: begin
					if (halt_exec) begin
						entry_pulse <= !deep_power_down_reg;
						if (deep_power_down_reg)
							mode_reg <= m_deep_sleep;
						else if (fast_osc_idle_en_reg && slow_osc_idle_en_reg)
							mode_reg <= m_idle_both_clocks;
						else if (fast_osc_idle_en_reg)
							mode_reg <= m_idle_fast_only;
						else if (slow_osc_idle_en_reg)
							mode_reg <= m_idle_slow_only;
						else
							mode_reg <= m_sleep;
					end
				end
				m_deep_sleep: begin
					if (port_fall || s_tw[1]) begin
						mode_reg <= m_run;
						wake_reset <= 1'b1;
					end
				end
				m_sleep, m_idle_slow_only, m_idle_both_clocks, m_idle_fast_only: begin
					if (!halt_exec)
						mode_reg <= m_run;
				end
				default: mode_reg <= m_run;
			endcase
		end
	end

	// remember which source ended deep sleep; the flags are loaded one cycle
	// later, when the port edge detector has already moved on
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wake_by_port_reg <= 1'b0;
			wake_by_tb_reg <= 1'b0;
		end else if (mode_reg == m_deep_sleep) begin
			wake_by_port_reg <= port_fall;
			wake_by_tb_reg <= s_tw[1];
		end
	end

	// watchdog and status side effects of sleep or idle entry
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			powerdown_flag_set <= 1'b0;
			watchdog_timeout_flag_clr <= 1'b0;
			watchdog_clear <= 1'b0;
			wake_restart <= 1'b0;
		end else begin
			powerdown_flag_set <= entry_pulse;
			watchdog_timeout_flag_clr <= entry_pulse;
			watchdog_clear <= entry_pulse;
			wake_restart <= wake_reset;
		end
	end

	// ----------------------------------------
	// oscillator and regulator gating
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pwr <= '0;
			mode <= m_run;
			regulator_lowpower_sel <= 1'b0;
			io_isolate <= 1'b0;
		end else begin
			mode <= mode_reg;
			regulator_lowpower_sel <= lp_reg;
			io_isolate <= io_iso_reg;
			pwr.regulator_on <= mode_reg != m_deep_sleep;
			pwr.cpu_clk_en <= mode_reg == m_run;
			pwr.fast_rc_osc_en <= irc_osc_en_reg && (mode_reg == m_run || ((mode_reg == m_idle_both_clocks
				|| mode_reg == m_idle_fast_only) && fast_osc_idle_en_reg));
			pwr.crystal_osc_en <= xtal_osc_en_reg && (mode_reg == m_run || ((mode_reg == m_idle_both_clocks
				|| mode_reg == m_idle_fast_only) && fast_osc_idle_en_reg));
			pwr.slow_rc_osc_en <= wdt_enable || mode_reg == m_run || mode_reg == m_idle_slow_only
				|| mode_reg == m_idle_both_clocks;
			pwr.fast_periph_en <= mode_reg == m_run || mode_reg == m_idle_both_clocks
				|| mode_reg == m_idle_fast_only;
			pwr.slow_periph_en <= mode_reg == m_run || mode_reg == m_idle_slow_only
				|| mode_reg == m_idle_both_clocks;
		end
	end

	// ----------------------------------------
	// system clock generation
	// ----------------------------------------
	logic fast_edge; // edge event of chosen fast source
	logic [1:0] xdiv_reg; // crystal pre and post divide count
	logic xtal_tick; // crystal edge after its own division
	logic [5:0] div_cnt_reg; // fast divide counter
	logic [2:0] div_act_reg; // divide code in force
	logic [6:0] div_len; // toggle period in fast edges
	logic slow_edge; // sub clock edge
	logic xtal_rise; // synced crystal rising edge
	logic xtal_any; // synced crystal edge of either sense
	logic xtal_by4; // crystal divided by four

	assign slow_edge = s_slw[1] ^ slw_prev;
	assign xtal_rise = s_xtl[1] && !xtl_prev;
	assign xtal_any = s_xtl[1] ^ xtl_prev;
	assign xtal_by4 = xtal_postdivide && xtal_predivide;
	// each edge of the divided fast clock is an event: undivided crystal gives both
	// crystal edges, by two each rising edge, by four every second rising edge
	assign xtal_tick = (xtal_predivide || xtal_postdivide) ? (xtal_rise && (xdiv_reg[0] || !xtal_by4))
		: xtal_any;
	// both edges of the fast clock count, so code 000 passes it undivided
	assign fast_edge = fast_src_sel_reg ? xtal_tick : (s_frc[1] ^ frc_prev);
	assign div_len = 7'h01 << div_act_reg;

	// crystal divider: by 1, 2 or 4 from the two divide bits
	always_ff @(posedge ref_clk) begin
		if (soft_rst || xtal_tick)
			xdiv_reg <= 2'h0;
		else if (s_xtl[1] && !xtl_prev)
			xdiv_reg <= xdiv_reg + 2'h1;
	end

	// divided fast clock or sub clock; new code applied only at a period boundary
	always_ff @(posedge ref_clk) begin
		if (soft_rst) begin
			div_cnt_reg <= 6'h00;
			div_act_reg <= 3'(`RST_SYSCLK_SEL >> `BIT_DIV_LO);
			sys_clk <= 1'b0;
		end else if (div_act_reg == `DIV_SUB) begin
			// sub path follows the slow level; leaving it waits for a low slow
			// phase so that no short high pulse reaches the system clock
			if (slow_edge) begin
				sys_clk <= s_slw[1];
				if (!s_slw[1] && sysclk_div_sel_reg != `DIV_SUB)
					div_act_reg <= sysclk_div_sel_reg;
			end
		end else if (fast_edge) begin
			// one half period of sys_clk is div_len fast clock edges
			if ({1'b0, div_cnt_reg} + 7'h01 >= div_len) begin
				div_cnt_reg <= 6'h00;
				sys_clk <= !sys_clk;
				if (sys_clk)
					div_act_reg <= sysclk_div_sel_reg;
			end else
				div_cnt_reg <= div_cnt_reg + 6'h01;
		end
	end
endmodule

// [clk_mode_params.svh]
// constants for the system clock and power mode controller
// Summary of operation
// - divide select picks fast/1..64, code 7 sub
// - source bit picks fast rc or crystal
// - crystal clock further divided by two bits
// - fast idle enable keeps fast osc in halt
// - slow idle enable keeps slow osc in halt
// - watchdog enable keeps slow rc running
// - slow mode sub clock from slow rc
// - regulator on in normal and slow modes
// - halt, both idle bits low enters sleep
// - halt, slow idle only enters idle_slow_only
// - halt, both idle bits high enters idle_both_clocks
// - halt, fast idle only enters idle_fast_only
// - halt with deep power-down enters deep sleep
// - rc enable clears then sets stable flag
// - crystal enable clears then sets stable flag
// - rc enable bit, powers up enabled
// - crystal enable bit, powers up disabled
// - sleep or idle entry sets flags, clears watchdog
// - deep sleep wakes on port or timebase, vector 0
// - deep sleep wake resets registers except por flag, isolation and wake flags
`ifndef CLK_MODE_PARAMS_SVH
`define CLK_MODE_PARAMS_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_SYSCLK_SEL 2'h0
`define ADDR_IRC_CTRL 2'h1
`define ADDR_XTAL_CTRL 2'h2
`define ADDR_PWR_CTRL 2'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_SLOW_IDLE 0
`define BIT_FAST_IDLE 1
`define BIT_FAST_SRC 3
`define BIT_DIV_LO 5
`define BIT_DIV_HI 7
`define BIT_OSC_EN 0
`define BIT_STABLE 1
`define BIT_DEEP_PD 0
`define BIT_IO_ISO 1
`define BIT_REG_LP 2
`define BIT_POR_FLAG 3
`define BIT_TB_WAKE 4
`define BIT_PORT_WAKE 7
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_SYSCLK_SEL 8'h20
`define RST_IRC_EN 1'b1
`define RST_XTAL_EN 1'b0
`define RST_PWR_CTRL 8'h08
`define DIV_SUB 3'h7
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 40
`define OSC_SETTLE_NS 2000
`define OSC_SETTLE_CYC ((`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [clk_mode_pkg.sv]
// types for the system clock and power mode controller
package clk_mode_pkg;
	typedef enum logic [2:0] {
		m_run, m_sleep, m_idle_slow_only, m_idle_both_clocks, m_idle_fast_only, m_deep_sleep
	} pwr_mode_t;
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
	typedef struct packed {
		logic fast_rc_osc_en;
		logic crystal_osc_en;
		logic slow_rc_osc_en;
		logic regulator_on;
		logic cpu_clk_en;
		logic fast_periph_en;
		logic slow_periph_en;
	} pwr_ctl_t;
endpackage

// [sysclk_mode_chk_sva.sv]
// concurrent checks on the ports of the clock and power mode controller
`timescale 1ns/1ns
module sysclk_mode_chk #(
	parameter int SETTLE_CYC = 2
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire clk_mode_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire logic halt_exec,
	input wire logic wdt_enable,
	input wire logic xtal_predivide,
	input wire logic xtal_postdivide,
	input wire logic fast_rc_clk_in,
	input wire logic crystal_clk_in,
	input wire logic slow_rc_clk_in,
	input wire logic port_wake_in,
	input wire logic timebase_wake_in,
	input wire logic sys_clk,
	input wire clk_mode_pkg::pwr_ctl_t pwr,
	input wire clk_mode_pkg::pwr_mode_t mode,
	input wire logic powerdown_flag_set,
	input wire logic watchdog_timeout_flag_clr,
	input wire logic watchdog_clear,
	input wire logic wake_restart,
	input wire logic regulator_lowpower_sel,
	input wire logic io_isolate
);
	import clk_mode_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// halt steps
	// ----------------------------------------
	// halt raised while running
	sequence s_halt_start;
		$rose(halt_exec) && mode == m_run;
	endsequence
	// first cycle of sleep or an idle mode
	sequence s_nap_entry;
		mode != $past(mode) && mode inside {m_sleep, m_idle_slow_only, m_idle_both_clocks, m_idle_fast_only};
	endsequence
	a_halt_leaves_run: assert property (s_halt_start |-> ##[1:3] mode != m_run)
		else $error("halt did not leave run");
	a_sleep_all_off: assert property (mode == m_sleep |-> !pwr.cpu_clk_en && !pwr.fast_periph_en && !pwr.slow_periph_en)
		else $error("clocks running in sleep");
	a_idle_slow_only: assert property (mode == m_idle_slow_only |-> !pwr.cpu_clk_en && pwr.slow_periph_en && !pwr.fast_periph_en)
		else $error("wrong clocks in slow idle");
	a_idle_both_on: assert property (mode == m_idle_both_clocks |-> !pwr.cpu_clk_en && pwr.slow_periph_en && pwr.fast_periph_en)
		else $error("wrong clocks in dual idle");
	a_idle_fast_only: assert property (mode == m_idle_fast_only |-> !pwr.cpu_clk_en && !pwr.slow_periph_en && pwr.fast_periph_en)
		else $error("wrong clocks in fast idle");
	a_deep_reg_off: assert property (mode == m_deep_sleep |-> !pwr.regulator_on && !pwr.cpu_clk_en && !powerdown_flag_set)
		else $error("deep sleep outputs wrong");
	a_run_reg_on: assert property (mode == m_run [*3] |-> pwr.regulator_on)
		else $error("regulator off while running");
	a_wdt_slow_osc: assert property (wdt_enable [*3] |-> pwr.slow_rc_osc_en)
		else $error("slow oscillator off with watchdog on");
	a_nap_pulses: assert property (s_nap_entry |-> powerdown_flag_set && watchdog_timeout_flag_clr && watchdog_clear)
		else $error("entry pulses missing");
	a_flag_one_cycle: assert property (powerdown_flag_set |=> !powerdown_flag_set)
		else $error("entry pulse too long");
	a_wake_after_deep: assert property (wake_restart |-> $past(mode) == m_deep_sleep || $past(mode, 2) == m_deep_sleep)
		else $error("restart without deep sleep");
	a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("read data outside read slot");
endmodule
bind system_clock_power_mode_ctrl sysclk_mode_chk #(.SETTLE_CYC(SETTLE_CYC)) sysclk_mode_chk_i (
	.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .halt_exec(halt_exec), .wdt_enable(wdt_enable),
	.xtal_predivide(xtal_predivide), .xtal_postdivide(xtal_postdivide), .fast_rc_clk_in(fast_rc_clk_in),
	.crystal_clk_in(crystal_clk_in), .slow_rc_clk_in(slow_rc_clk_in), .port_wake_in(port_wake_in),
	.timebase_wake_in(timebase_wake_in), .sys_clk(sys_clk), .pwr(pwr), .mode(mode),
	.powerdown_flag_set(powerdown_flag_set), .watchdog_timeout_flag_clr(watchdog_timeout_flag_clr),
	.watchdog_clear(watchdog_clear), .wake_restart(wake_restart),
	.regulator_lowpower_sel(regulator_lowpower_sel), .io_isolate(io_isolate));

// [tb_system_clock_power_mode_ctrl.sv]
// self-checking bench for the clock and power mode controller
`timescale 1ns/1ns
`include "clk_mode_params.svh"
module tb_system_clock_power_mode_ctrl;
	import clk_mode_pkg::*;
	logic ref_clk = 0, rst = 1, halt_exec = 0, wdt_enable = 0, xtal_predivide = 0, xtal_postdivide = 0;
	logic fast_rc_clk_in = 0, crystal_clk_in = 0, slow_rc_clk_in = 0, port_wake_in = 1, timebase_wake_in = 0;
	reg_req_t req = '0;
	logic [7:0] rdata, d;
	logic sys_clk, powerdown_flag_set, watchdog_timeout_flag_clr, watchdog_clear, wake_restart, lp_sel, iso;
	pwr_ctl_t pwr;
	pwr_mode_t mode;
	int n_errors = 0, checks = 0, n_pdf = 0, n_wake = 0, n_rise = 0;
	int code_t[4] = '{0, 2, 0, 7}, fhs_t[4] = '{0, 0, 1, 0}, per_t[4] = '{206, 824, 564, 1006};
	system_clock_power_mode_ctrl #(.SETTLE_CYC(2)) system_clock_power_mode_ctrl_i (
		.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .halt_exec(halt_exec), .wdt_enable(wdt_enable),
		.xtal_predivide(xtal_predivide), .xtal_postdivide(xtal_postdivide), .fast_rc_clk_in(fast_rc_clk_in),
		.crystal_clk_in(crystal_clk_in), .slow_rc_clk_in(slow_rc_clk_in), .port_wake_in(port_wake_in),
		.timebase_wake_in(timebase_wake_in), .sys_clk(sys_clk), .pwr(pwr), .mode(mode),
		.powerdown_flag_set(powerdown_flag_set), .watchdog_timeout_flag_clr(watchdog_timeout_flag_clr),
		.watchdog_clear(watchdog_clear), .wake_restart(wake_restart), .regulator_lowpower_sel(lp_sel),
		.io_isolate(iso));
	// ----------------------------------------
	// clocks, oscillators and event counters
	// ----------------------------------------
	initial forever #20 ref_clk = ~ref_clk;
	initial forever #103 fast_rc_clk_in = ~fast_rc_clk_in;
	initial forever #141 crystal_clk_in = ~crystal_clk_in;
	initial forever #503 slow_rc_clk_in = ~slow_rc_clk_in;
	always @(posedge sys_clk) n_rise++;
	// count the one-cycle entry and restart pulses
	always @(posedge ref_clk) begin
		if (powerdown_flag_set === 1'b1) n_pdf++;
		if (wake_restart === 1'b1) n_wake++;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge ref_clk) req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk) req <= '0;
	endtask
	// read, data taken in the cycle after the strobe
	task automatic rchk(input logic [1:0] a, input logic [7:0] exp);
		@(posedge ref_clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk) req <= '0;
		@(negedge ref_clk) chk($sformatf("reg %0d", a), rdata, exp);
	endtask
	function automatic pwr_mode_t exp_mode(input logic pd, input logic fi, input logic si);
		if (pd) return m_deep_sleep;
		case ({fi, si})
			2'b00: return m_sleep;
			2'b01: return m_idle_slow_only;
			2'b11: return m_idle_both_clocks;
			default: return m_idle_fast_only;
		endcase
	endfunction
	task automatic final_report;
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		cyc(30000);
		n_errors++;
		final_report();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'he785));
		cyc(2);
		rst <= 1'b0;
		cyc(40);
		rchk(`ADDR_SYSCLK_SEL, `RST_SYSCLK_SEL);
		rchk(`ADDR_IRC_CTRL, 8'h03);
		rchk(`ADDR_XTAL_CTRL, 8'h00);
		rchk(`ADDR_PWR_CTRL, `RST_PWR_CTRL);
		wr(`ADDR_IRC_CTRL, 8'h00);
		wr(`ADDR_IRC_CTRL, 8'h01);
		rchk(`ADDR_IRC_CTRL, 8'h01);
		wr(`ADDR_XTAL_CTRL, 8'h01);
		rchk(`ADDR_XTAL_CTRL, 8'h01);
		cyc(60);
		rchk(`ADDR_IRC_CTRL, 8'h03);
		rchk(`ADDR_XTAL_CTRL, 8'h03);
		@(negedge ref_clk) chk("crystal enable", {7'h00, pwr.crystal_osc_en}, 8'h01);
		// regulator low power and isolation bits reach their outputs
		wr(`ADDR_PWR_CTRL, 8'h0e);
		cyc(2);
		@(negedge ref_clk) chk("lp and iso", {6'h00, lp_sel, iso}, 8'h03);
		rchk(`ADDR_PWR_CTRL, 8'h0e);
		// random selects, unused bits read back as zero
		repeat (4) begin
			d = 8'($urandom);
			wr(`ADDR_SYSCLK_SEL, d);
			rchk(`ADDR_SYSCLK_SEL, d & 8'heb);
		end
		// system clock rate against source and divide code
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk) xtal_predivide <= fhs_t[i][0];
			wr(`ADDR_SYSCLK_SEL, 8'(code_t[i] << 5) | 8'(fhs_t[i] << 3));
			cyc(600);
			n_rise = 0;
			cyc(2000);
			chk("sys_clk edges", 8'((n_rise * per_t[i] + 4000) / 8000), 8'h0a);
		end
		// every halt mode, watchdog off then on
		for (int k = 0; k < 10; k++) begin
			logic pd, fi, si;
			int np, nw;
			pd = (k % 5 == 4);
			{fi, si} = pd ? 2'($urandom) : 2'(k % 5);
			@(posedge ref_clk) wdt_enable <= (k >= 5);
			wr(`ADDR_SYSCLK_SEL, {3'h1, 3'h0, fi, si});
			wr(`ADDR_PWR_CTRL, {7'h04, pd});
			np = n_pdf;
			nw = n_wake;
			@(posedge ref_clk) halt_exec <= 1'b1;
			cyc(4);
			@(negedge ref_clk) chk("mode", 8'(mode), 8'(exp_mode(pd, fi, si)));
			chk("pwr", {2'h0, pwr.fast_rc_osc_en, pwr.slow_rc_osc_en, pwr.regulator_on, pwr.cpu_clk_en,
				pwr.fast_periph_en, pwr.slow_periph_en}, {2'h0, fi & !pd, (si & !pd) | wdt_enable, !pd, 1'b0,
				fi & !pd, si & !pd});
			chk("entry pulses", 8'(n_pdf - np), {7'h00, !pd});
			@(posedge ref_clk) halt_exec <= 1'b0;
			if (pd && k < 5) begin
				@(posedge ref_clk) port_wake_in <= 1'b0;
				cyc(4);
				port_wake_in <= 1'b1;
			end else if (pd) begin
				@(posedge ref_clk) timebase_wake_in <= 1'b1;
				cyc(4);
				timebase_wake_in <= 1'b0;
			end
			for (int w = 0; w < 60 && mode !== m_run; w++) @(posedge ref_clk);
			cyc(4);
			@(negedge ref_clk) chk("regulator", {7'h00, pwr.regulator_on}, 8'h01);
			if (pd) begin
				chk("restart pulses", 8'(n_wake - nw), 8'h01);
				rchk(`ADDR_SYSCLK_SEL, `RST_SYSCLK_SEL);
				rchk(`ADDR_PWR_CTRL, (k < 5) ? 8'h88 : 8'h18);
			end
		end
		final_report();
	end
endmodule
